/* File: hdl/sspc_pkg.sv */
// package with register map, field positions and timing constants of the packet controller
// Contract
// - ignore bit set: reception always on, no end-of-packet
// - ignore bit clear: enable pin qualifies reception
// - receive irq enable raises irq on buffer full
// - transmit irq enable raises irq on buffer empty
// - clock source: divider when 0, receive clock when 1
// - receive edge: 1 rising, 0 falling
// - transmit edge: 1 rising, 0 falling
// - full flag set on byte received, software clears
// - two-bit line mode selects framed/spi/usart/uart behaviour
// - enable pin falling edge sets end-of-packet flag
// - empty flag set on shift load, cleared on write
// - header match cleared only by writing zero
// - long header select: 32 bits else 16
package sspc_pkg;
  // word indices on the register bus (byte address divided by four)
  localparam logic [7:0] ADDR_MAIN = 8'hc0 >> 0;
  localparam int IDX_MAIN = 'hc0;
  localparam int IDX_STATUS = 'hc1;
  localparam int IDX_HDRCTL = 'hc2;
  localparam int IDX_HDR = 'hc3;
  localparam int IDX_DATA = 'hc4;
  localparam int IDX_BAUD = 'hc5;
  localparam int IDX_IRQ_STAT = 'hc6;
  localparam int IDX_IRQ_EN = 'hc7;
  localparam int IDX_IRQ_CLR = 'hc8;
  localparam int ADDR_W = 12;
  // main control field positions
  localparam int B_IFEN = 0;
  localparam int B_TXED = 1;
  localparam int B_RXED = 2;
  localparam int B_TXCLK = 3;
  localparam int B_TXIE = 4;
  localparam int B_RXIE = 5;
  // status field positions
  localparam int B_MODE0 = 0;
  localparam int B_RXOFF = 2;
  localparam int B_EOP = 3;
  localparam int B_TXHEN = 4;
  localparam int B_RXHEN = 5;
  localparam int B_TXEMPTY = 6;
  localparam int B_RXFULL = 7;
  // header control field positions
  localparam int B_TXLOAD = 0;
  localparam int B_RXMATCH = 1;
  localparam int B_LONG_HEADER_SELECT = 2;
  localparam int B_TXHIE = 3;
  localparam int B_RXHIE = 4;
  localparam int B_EOPIE = 5;
  localparam int B_TXCLR = 6;
  localparam int B_RXCLR = 7;
  // interrupt event bit positions
  localparam int E_RX = 0;
  localparam int E_TX = 1;
  localparam int E_EOP = 2;
  localparam int E_RXH = 3;
  localparam int E_TXH = 4;
  localparam int N_EV = 5;
  // reset values
  localparam logic [7:0] RST_MAIN = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // line modes
  typedef enum logic [1:0] {
    MODE_FRAMED = 2'h0,
    MODE_SPI = 2'h1,
    MODE_USART = 2'h2,
    MODE_UART = 2'h3
  } sspc_mode_t;
  // baud divider: toggles every (div+1) steps... prescale of four system clocks per step
  localparam int BAUD_PRESCALE = 4;
  localparam int BYTE_BITS = 8;
endpackage

/* File: hdl/sspc_ctrl.sv */
// packet controller: register slave, transmit and receive shifters, events
`timescale 1ns/1ps
module sspc_ctrl
  import sspc_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt
  output logic irq,
  // transmit pins
  output logic xmit_clock,
  output logic xmit_enable,
  output logic xmit_data,
  output logic xmit_clock_oe_n,
  output logic xmit_enable_oe_n,
  // receive pins
  input wire logic recv_clock,
  input wire logic recv_data,
  input wire logic recv_enable_pin
);

  // decoded word index
  logic [ADDR_W-3:0] idx;
  assign idx = avs_address[ADDR_W-1:2];

  // registers
  logic [7:0] main_r, main_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic rxoff_r, rxoff_nxt, eop_r, eop_nxt;
  logic txhen_r, txhen_nxt, rxhen_r, rxhen_nxt;
  logic txempty_r, txempty_nxt, rxfull_r, rxfull_nxt;
  logic long_header_select_r, long_header_select_nxt, rxmatch_r, rxmatch_nxt, txload_r, txload_nxt;
  logic [2:0] hie_r, hie_nxt; // eop, rxh, txh enables
  logic [7:0] hdr_r, hdr_nxt, txbuf_r, txbuf_nxt, rxbuf_r, rxbuf_nxt, baud_r, baud_nxt;
  logic [N_EV-1:0] ist_r, ist_nxt, ien_r, ien_nxt;
  logic ack_r, ack_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  // datapath
  logic [7:0] txsh_r, txsh_nxt, rxsh_r, rxsh_nxt;
  logic [3:0] txcnt_r, txcnt_nxt, rxcnt_r, rxcnt_nxt;
  logic [1:0] txhb_r, txhb_nxt, rxhb_r, rxhb_nxt; // header byte counters
  logic txbusy_r, txbusy_nxt, txfull_r, txfull_nxt;
  logic rxhok_r, rxhok_nxt;
  logic [9:0] bdiv_r, bdiv_nxt;
  logic gclk_r, gclk_nxt;
  logic rc_q_r, re_q_r, gclk_q_r;
  logic rx_rose_q; // full flag rose at the last edge

  // one-cycle answer: waitrequest low in the cycle after the request
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  assign avs_readdata = rdata_r;
  // writes land at the edge that ends the transfer, never while waitrequest stands high
  wire wr = avs_write & ack_r;
  wire rd = avs_read & ~ack_r;
  wire [7:0] wd = avs_writedata[7:0];

  // interface enable and reception qualification
  wire en = main_r[B_IFEN];
  wire rx_qual = rxoff_r | recv_enable_pin;

  // transmit clock source and edges
  wire tclk = main_r[B_TXCLK] ? recv_clock : gclk_r;
  wire tprev = main_r[B_TXCLK] ? rc_q_r : gclk_q_r;
  wire t_edge = main_r[B_TXED] ? (tclk & ~tprev) : (~tclk & tprev);
  wire r_edge = main_r[B_RXED] ? (recv_clock & ~rc_q_r) : (~recv_clock & rc_q_r);
  wire eop_ev = en & ~rxoff_r & re_q_r & ~recv_enable_pin;

  // header byte expected or sent at position n
  function automatic logic [7:0] hdr_byte(input logic [7:0] h, input logic [1:0] n);
    hdr_byte = n[0] ? ~h : h;
  endfunction

  // next-state for registers and datapath
  always_comb begin
    logic rx_done, tx_load, rxh_ev, txh_ev;
    logic [7:0] rbyte;
    rx_done = 1'b0;
    tx_load = 1'b0;
    rxh_ev = 1'b0;
    txh_ev = 1'b0;
    rbyte = {recv_data, rxsh_r[7:1]};
    main_nxt = main_r;
    mode_nxt = mode_r;
    rxoff_nxt = rxoff_r;
    eop_nxt = eop_r;
    txhen_nxt = txhen_r;
    rxhen_nxt = rxhen_r;
    txempty_nxt = txempty_r;
    rxfull_nxt = rxfull_r;
    long_header_select_nxt = long_header_select_r;
    rxmatch_nxt = rxmatch_r;
    txload_nxt = txload_r;
    hie_nxt = hie_r;
    hdr_nxt = hdr_r;
    txbuf_nxt = txbuf_r;
    rxbuf_nxt = rxbuf_r;
    baud_nxt = baud_r;
    ien_nxt = ien_r;
    ist_nxt = ist_r;
    ack_nxt = (avs_read | avs_write) & ~ack_r;
    rdata_nxt = rdata_r;
    txsh_nxt = txsh_r;
    rxsh_nxt = rxsh_r;
    txcnt_nxt = txcnt_r;
    rxcnt_nxt = rxcnt_r;
    txhb_nxt = txhb_r;
    rxhb_nxt = rxhb_r;
    txbusy_nxt = txbusy_r;
    txfull_nxt = txfull_r;
    rxhok_nxt = rxhok_r;
    gclk_nxt = gclk_r;
    bdiv_nxt = bdiv_r;
    // baud divider: half period of BAUD_PRESCALE*(div+1) clocks
    if (en && bdiv_r == 10'(BAUD_PRESCALE * (int'(baud_r) + 1) - 1)) begin
      bdiv_nxt = '0;
      gclk_nxt = ~gclk_r;
    end else if (en) begin
      bdiv_nxt = bdiv_r + 10'h001;
    end
    // software writes
    if (wr) begin
      unique case (int'(idx))
        IDX_MAIN: main_nxt = wd;
        IDX_STATUS: begin
          mode_nxt = wd[B_MODE0 +: 2];
          rxoff_nxt = wd[B_RXOFF];
          if (!wd[B_EOP]) eop_nxt = 1'b0;
          if (!wd[B_RXFULL]) rxfull_nxt = 1'b0;
          if (wd[B_TXHEN]) txhen_nxt = 1'b1;
          if (wd[B_RXHEN]) rxhen_nxt = 1'b1;
        end
        IDX_HDRCTL: begin
          long_header_select_nxt = wd[B_LONG_HEADER_SELECT];
          hie_nxt = {wd[B_EOPIE], wd[B_RXHIE], wd[B_TXHIE]};
          if (!wd[B_RXCLR]) rxmatch_nxt = 1'b0;
          if (!wd[B_TXCLR]) txload_nxt = 1'b0;
        end
        IDX_HDR: hdr_nxt = wd;
        IDX_DATA: begin
          txbuf_nxt = wd;
          txfull_nxt = 1'b1;
          txempty_nxt = 1'b0;
        end
        IDX_BAUD: baud_nxt = wd;
        IDX_IRQ_EN: ien_nxt = wd[N_EV-1:0];
        IDX_IRQ_CLR: ist_nxt = ist_r & ~wd[N_EV-1:0];
        default: ;
      endcase
    end
    // read mux, unmapped reads zero
    if (rd) begin
      unique case (int'(idx))
        IDX_MAIN: rdata_nxt = {24'h0, 2'h0, main_r[5:0]};
        IDX_STATUS: rdata_nxt = {24'h0, rxfull_r, txempty_r, rxhen_r, txhen_r, eop_r,
                                 rxoff_r, mode_r};
        IDX_HDRCTL: rdata_nxt = {24'h0, 2'h0, hie_r, long_header_select_r, rxmatch_r, txload_r};
        IDX_HDR: rdata_nxt = {24'h0, hdr_r};
        IDX_DATA: rdata_nxt = {24'h0, rxbuf_r};
        IDX_BAUD: rdata_nxt = {24'h0, baud_r};
        IDX_IRQ_STAT: rdata_nxt = {27'h0, ist_r};
        IDX_IRQ_EN: rdata_nxt = {27'h0, ien_r};
        default: rdata_nxt = 32'h0;
      endcase
    end
    // transmit shifter, lsb first, header bytes ahead of data
    if (!en) begin
      txbusy_nxt = 1'b0;
      txcnt_nxt = '0;
      txhb_nxt = '0;
    end else if (t_edge) begin
      if (txbusy_r && txcnt_r != 4'(BYTE_BITS - 1)) begin
        txsh_nxt = {1'b0, txsh_r[7:1]};
        txcnt_nxt = txcnt_r + 4'h1;
      end else if (txhen_r && (txfull_r || txhb_r != 2'h0)) begin
        txsh_nxt = hdr_byte(hdr_r, txhb_r);
        txbusy_nxt = 1'b1;
        txcnt_nxt = '0;
        if (txhb_r == (long_header_select_r ? 2'h2 : 2'h0)) txh_ev = 1'b1;
        if (txhb_r == (long_header_select_r ? 2'h3 : 2'h1)) begin
          txhen_nxt = 1'b0;
          txhb_nxt = '0;
        end else begin
          txhb_nxt = txhb_r + 2'h1;
        end
      end else if (txfull_r) begin
        txsh_nxt = txbuf_r;
        txbusy_nxt = 1'b1;
        txcnt_nxt = '0;
        txfull_nxt = 1'b0;
        tx_load = 1'b1;
      end else begin
        txbusy_nxt = 1'b0;
      end
    end
    if (tx_load) txempty_nxt = 1'b1;
    if (txh_ev) txload_nxt = 1'b1;
    // receive shifter, qualified by the enable pin unless ignored
    if (!en || !rx_qual) begin
      rxcnt_nxt = '0;
      if (!en) rxhb_nxt = '0;
    end else if (r_edge) begin
      rxsh_nxt = rbyte;
      if (rxcnt_r == 4'(BYTE_BITS - 1)) begin
        rxcnt_nxt = '0;
        if (rxhen_r) begin
          rxhok_nxt = (rxhb_r == 2'h0 ? 1'b1 : rxhok_r) & (rbyte == hdr_byte(hdr_r, rxhb_r));
          if (rxhb_r == (long_header_select_r ? 2'h3 : 2'h1)) begin
            rxhen_nxt = 1'b0;
            rxhb_nxt = '0;
            rxh_ev = rxhok_nxt;
          end else begin
            rxhb_nxt = rxhb_r + 2'h1;
          end
        end else begin
          rxbuf_nxt = rbyte;
          rx_done = 1'b1;
        end
      end else begin
        rxcnt_nxt = rxcnt_r + 4'h1;
      end
    end
    // hardware sets win over software clears
    if (rx_done) rxfull_nxt = 1'b1;
    if (rxh_ev) rxmatch_nxt = 1'b1;
    if (eop_ev) eop_nxt = 1'b1;
    ist_nxt[E_RX] = ist_nxt[E_RX] | (rx_done & main_r[B_RXIE]);
    ist_nxt[E_TX] = ist_nxt[E_TX] | (tx_load & main_r[B_TXIE]);
    ist_nxt[E_EOP] = ist_nxt[E_EOP] | (eop_ev & hie_r[2]);
    ist_nxt[E_RXH] = ist_nxt[E_RXH] | (rxh_ev & hie_r[1]);
    ist_nxt[E_TXH] = ist_nxt[E_TXH] | (txh_ev & hie_r[0]);
  end

  // register everything
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      main_r <= RST_MAIN;
      mode_r <= MODE_FRAMED;
      {rxoff_r, eop_r, txhen_r, rxhen_r, rxfull_r} <= '0;
      txempty_r <= 1'b1;
      {long_header_select_r, rxmatch_r, txload_r} <= '0;
      hie_r <= '0;
      {hdr_r, txbuf_r, rxbuf_r, baud_r} <= {4{RST_BYTE}};
      ist_r <= '0;
      ien_r <= '0;
      ack_r <= 1'b0;
      rdata_r <= 32'h0;
      {txsh_r, rxsh_r} <= {2{RST_BYTE}};
      {txcnt_r, rxcnt_r} <= '0;
      {txhb_r, rxhb_r} <= '0;
      {txbusy_r, txfull_r, rxhok_r, gclk_r} <= '0;
      bdiv_r <= '0;
      {rc_q_r, re_q_r, gclk_q_r} <= '0;
    end else begin
      main_r <= main_nxt;
      mode_r <= mode_nxt;
      {rxoff_r, eop_r, txhen_r, rxhen_r, rxfull_r} <=
        {rxoff_nxt, eop_nxt, txhen_nxt, rxhen_nxt, rxfull_nxt};
      txempty_r <= txempty_nxt;
      {long_header_select_r, rxmatch_r, txload_r} <= {long_header_select_nxt, rxmatch_nxt, txload_nxt};
      hie_r <= hie_nxt;
      {hdr_r, txbuf_r, rxbuf_r, baud_r} <= {hdr_nxt, txbuf_nxt, rxbuf_nxt, baud_nxt};
      ist_r <= ist_nxt;
      ien_r <= ien_nxt;
      ack_r <= ack_nxt;
      rdata_r <= rdata_nxt;
      {txsh_r, rxsh_r} <= {txsh_nxt, rxsh_nxt};
      {txcnt_r, rxcnt_r} <= {txcnt_nxt, rxcnt_nxt};
      {txhb_r, rxhb_r} <= {txhb_nxt, rxhb_nxt};
      {txbusy_r, txfull_r, rxhok_r, gclk_r} <= {txbusy_nxt, txfull_nxt, rxhok_nxt, gclk_nxt};
      bdiv_r <= bdiv_nxt;
      {rc_q_r, re_q_r, gclk_q_r} <= {recv_clock, recv_enable_pin, gclk_r};
    end
  end

  // line behaviour per mode: idle data low, clock per mode
  always_comb begin
    xmit_data = txbusy_r & txsh_r[0];
    xmit_clock_oe_n = (mode_r == MODE_UART);
    xmit_enable_oe_n = (mode_r != MODE_FRAMED);
    xmit_enable = (mode_r == MODE_FRAMED) & txbusy_r;
    xmit_clock = (mode_r == MODE_SPI) ? (tclk & txbusy_r) : (tclk & en);
  end

  assign irq = |(ist_r & ien_r);

  // end-of-packet only on a falling enable pin with the pin in use
  eop_edge_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (en && !rxoff_r && $fell(recv_enable_pin)) |=> eop_r)
    else $error("eop not set on falling enable pin");
  eop_ignore_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (rxoff_r && !eop_r && !wr) |=> !eop_r)
    else $error("eop set while enable pin ignored");
  full_irq_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (rx_rose_q && main_r[B_RXIE]) |-> ist_r[E_RX])
    else $error("rx event missing");
  empty_irq_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $rose(txempty_r) && $past(main_r[B_TXIE]) |-> ist_r[E_TX])
    else $error("tx event missing");
  write_empty_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr && int'(idx) == IDX_DATA && !(en && t_edge)) |=> !txempty_r)
    else $error("data write did not clear empty");
  match_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr && int'(idx) == IDX_HDRCTL && wd[B_RXCLR] && rxmatch_r) |=> rxmatch_r)
    else $error("match cleared by one");
  hen_sticky_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (txhen_r && !(en && t_edge)) |=> txhen_r)
    else $error("header enable cleared by software");
  stop_idle_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !en |=> (rxcnt_r == 4'h0 && !txbusy_r))
    else $error("activity while disabled");
  mode_pins_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (mode_r != MODE_FRAMED) |-> (xmit_enable_oe_n && !xmit_enable))
    else $error("enable pin driven outside framed mode");
  // final bit of a data byte taken on the selected receive edge
  sequence data_byte_end_s;
    en && rx_qual && r_edge && rxcnt_r == 4'(BYTE_BITS - 1) && !rxhen_r;
  endsequence
  // final bit of a header byte while the receive header is expected
  sequence hdr_byte_end_s;
    en && rx_qual && r_edge && rxcnt_r == 4'(BYTE_BITS - 1) && rxhen_r;
  endsequence
  // a completed data byte always marks the receive buffer full
  buf_full_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    data_byte_end_s |=> rxfull_r)
    else $error("receive buffer full not set");
  // header length decides which byte ends the receive header
  rx_hdr_end_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    hdr_byte_end_s ##0 (rxhb_r == (long_header_select_r ? 2'h3 : 2'h1)) |=> !rxhen_r)
    else $error("receive header enable not cleared");
  // receive header enable only drops on a sampled bit
  rx_hen_sticky_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (rxhen_r && !(en && rx_qual && r_edge)) |=> rxhen_r)
    else $error("receive header enable cleared by software");
  // a low enable pin in use holds the receive bit count at zero
  rx_stop_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (en && !rxoff_r && !recv_enable_pin) |=> rxcnt_r == 4'h0)
    else $error("reception while enable pin low");
  always_ff @(posedge ref_clk) begin
    rx_rose_q <= reset_n & rxfull_nxt & ~rxfull_r;
  end
endmodule // sspc_ctrl

/* File: tb/sspc_link_partner.sv */
// far-side controller model driving the receive pins of the block
`timescale 1ns/1ps
module sspc_link_partner #(
  parameter int HALF = 4 // system clocks per link half period
) (
  // system clock
  input wire logic ref_clk,
  // receive pins of the block
  output logic recv_clock,
  output logic recv_data,
  output logic recv_enable_pin
);
  // link clock stands low outside frames
  initial begin
    recv_clock = 1'b0;
    recv_data = 1'b0;
    recv_enable_pin = 1'b0;
  end
  // idle for some system clocks
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // marks valid receive data while high
  task automatic set_enable(input logic v);
    @(posedge ref_clk);
    recv_enable_pin <= v;
  endtask
  // lsb first; data moves on the edge that is not sampled
  task automatic send(input logic [7:0] b, input logic rise);
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      recv_clock <= ~rise;
      recv_data <= b[i];
      tick(HALF);
      recv_clock <= rise;
      tick(HALF - 1);
    end
    tick(HALF);
    // released data line shows the inverse of the last bit
    recv_clock <= 1'b0;
    recv_data <= ~b[7];
  endtask
endmodule // sspc_link_partner

/* File: tb/sspc_ctrl_bench.sv */
// self-checking bench: register bus, interrupts and receive link
`timescale 1ns/1ps
module sspc_ctrl_bench
  import sspc_pkg::*;
;
  // clock, reset and bus
  logic ref_clk, reset_n, avs_read, avs_write, avs_waitrequest, irq;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata;
  // link pins
  logic recv_clock, recv_data, recv_enable_pin;
  // transmit pins and serial capture
  logic xmit_clock, xmit_enable, xmit_data, xmit_clock_oe_n, xmit_enable_oe_n, tx_clk_q;
  logic [7:0] tx_shift;
  int tx_bits;
  // report counters
  int bad_count, comparisons, cycles;

  sspc_ctrl sspc_ctrl_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .xmit_clock(xmit_clock), .xmit_enable(xmit_enable), .xmit_data(xmit_data),
    .xmit_clock_oe_n(xmit_clock_oe_n), .xmit_enable_oe_n(xmit_enable_oe_n),
    .recv_clock(recv_clock), .recv_data(recv_data),
    .recv_enable_pin(recv_enable_pin)
  );
  sspc_link_partner sspc_link_partner_inst (
    .ref_clk(ref_clk), .recv_clock(recv_clock), .recv_data(recv_data),
    .recv_enable_pin(recv_enable_pin)
  );

  // 50 ns system clock
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // verdict and end of run
  task automatic print_verdict();
    $display("counts: %0d mismatches in %0d comparisons", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // mismatch report
  task automatic fail(input string s);
    bad_count++;
    $display("unexpected at %0t: %s", $time, s);
  endtask
  // one avalon transfer; held until waitrequest is seen low
  task automatic bus(input logic wr, input int idx, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    @(posedge ref_clk);
    avs_address <= 12'(idx * 4);
    avs_writedata <= {24'h000000, d};
    avs_read <= ~wr;
    avs_write <= wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0 && n < 64) begin
      @(posedge ref_clk);
      n++;
    end
    if (n == 64) fail("bus hang");
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  // register write
  task automatic wr(input int idx, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, idx, d, q);
  endtask
  // register read and masked compare
  task automatic check(input int idx, input logic [7:0] m, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, idx, 8'h00, q);
    comparisons++;
    if ((q & m) !== e) fail($sformatf("reg %0h read %0h want %0h", idx, q, e));
  endtask
  // interrupt level compare, settled after the edge
  task automatic check_irq(input logic e);
    @(negedge ref_clk);
    comparisons++;
    if (irq !== e) fail("irq level");
  endtask
  // output enable pair compare {clock, enable}, settled after the edge
  task automatic check_oe(input logic [1:0] e);
    @(negedge ref_clk);
    comparisons++;
    if ({xmit_clock_oe_n, xmit_enable_oe_n} !== e) fail("pin ownership");
  endtask
  // captured serial value compare
  task automatic check_line(input logic [7:0] got, input logic [7:0] e, input string s);
    comparisons++;
    if (got !== e) fail($sformatf("%s got %0h want %0h", s, got, e));
  endtask

  // hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail("timeout");
      print_verdict();
    end
  end

  // serial capture: framed bits taken on the falling link clock while enable is high
  always @(negedge ref_clk) begin
    tx_clk_q <= xmit_clock;
    if (tx_clk_q === 1'b1 && xmit_clock === 1'b0 && xmit_enable === 1'b1) begin
      tx_shift <= {xmit_data, tx_shift[7:1]};
      tx_bits <= tx_bits + 1;
    end
  end

  // main sequence
  initial begin
    int n;
    reset_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    bad_count = 0;
    comparisons = 0;
    cycles = 0;
    tx_bits = 0;
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'b1;
    // reset values and an unmapped place
    check(IDX_MAIN, 8'hff, RST_MAIN);
    check(IDX_STATUS, 8'hff, 8'h40);
    check(IDX_HDRCTL, 8'hff, 8'h00);
    check('hff, 8'hff, 8'h00);
    // control fields held while disabled
    wr(IDX_MAIN, 8'h3e);
    check(IDX_MAIN, 8'hff, 8'h3e);
    wr(IDX_MAIN, 8'h00);
    wr(IDX_HDRCTL, 8'h04);
    check(IDX_HDRCTL, 8'h04, 8'h04);
    wr(IDX_HDRCTL, 8'h00);
    for (int m = 0; m < 4; m++) begin
      wr(IDX_STATUS, 8'(m));
      check(IDX_STATUS, 8'h03, 8'(m));
      check_oe(m == 3 ? 2'h3 : (m == 0 ? 2'h0 : 2'h1));
    end
    // transmit gated until enable, then empty event raises irq
    wr(IDX_IRQ_CLR, 8'h1f);
    wr(IDX_DATA, 8'h55);
    wr(IDX_IRQ_EN, 8'h02);
    check(IDX_STATUS, 8'h40, 8'h00);
    check_irq(1'b0);
    wr(IDX_MAIN, 8'h11);
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    check_irq(1'b1);
    check(IDX_STATUS, 8'h40, 8'h40);
    wr(IDX_IRQ_EN, 8'h00);
    check_irq(1'b0);
    // framed transmit: byte leaves lsb first, launched on the rising link clock
    wr(IDX_MAIN, 8'h00);
    wr(IDX_STATUS, 8'h00);
    check_oe(2'h0);
    wr(IDX_MAIN, 8'h03);
    wr(IDX_DATA, 8'ha6);
    n = 0;
    while (tx_bits < 8 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    repeat (20) @(negedge ref_clk);
    check_line(tx_shift, 8'ha6, "serial byte");
    check_line(8'(tx_bits), 8'h08, "serial bit count");
    // receive on rising edge with pin qualifying
    wr(IDX_MAIN, 8'h25);
    wr(IDX_IRQ_CLR, 8'h1f);
    wr(IDX_IRQ_EN, 8'h01);
    sspc_link_partner_inst.set_enable(1'b1);
    sspc_link_partner_inst.send(8'ha5, 1'b1);
    sspc_link_partner_inst.tick(8);
    check(IDX_STATUS, 8'h80, 8'h80);
    check_irq(1'b1);
    check(IDX_DATA, 8'hff, 8'ha5);
    sspc_link_partner_inst.set_enable(1'b0);
    sspc_link_partner_inst.tick(8);
    check(IDX_STATUS, 8'h08, 8'h08);
    wr(IDX_STATUS, 8'h00);
    wr(IDX_IRQ_CLR, 8'h1f);
    check_irq(1'b0);
    check(IDX_STATUS, 8'h88, 8'h00);
    // falling edge sampling, then pin low refuses data
    wr(IDX_MAIN, 8'h21);
    sspc_link_partner_inst.set_enable(1'b1);
    sspc_link_partner_inst.send(8'h3c, 1'b0);
    sspc_link_partner_inst.tick(8);
    check(IDX_DATA, 8'hff, 8'h3c);
    sspc_link_partner_inst.set_enable(1'b0);
    sspc_link_partner_inst.tick(8);
    wr(IDX_STATUS, 8'h00);
    sspc_link_partner_inst.send(8'h77, 1'b0);
    sspc_link_partner_inst.tick(8);
    check(IDX_STATUS, 8'h80, 8'h00);
    // pin ignored: always receiving, no end of packet
    wr(IDX_STATUS, 8'h04);
    sspc_link_partner_inst.send(8'h96, 1'b0);
    sspc_link_partner_inst.tick(8);
    check(IDX_DATA, 8'hff, 8'h96);
    sspc_link_partner_inst.set_enable(1'b1);
    sspc_link_partner_inst.set_enable(1'b0);
    sspc_link_partner_inst.tick(8);
    check(IDX_STATUS, 8'h0c, 8'h04);
    // header enable cannot be cleared by software
    wr(IDX_STATUS, 8'h30);
    check(IDX_STATUS, 8'h30, 8'h30);
    wr(IDX_STATUS, 8'h00);
    check(IDX_STATUS, 8'h30, 8'h30);
    // two-byte receive header self-clears its enable and flags a match
    sspc_link_partner_inst.set_enable(1'b1);
    sspc_link_partner_inst.send(8'h00, 1'b0);
    sspc_link_partner_inst.send(8'hff, 1'b0);
    sspc_link_partner_inst.tick(8);
    check(IDX_STATUS, 8'h30, 8'h10);
    check(IDX_HDRCTL, 8'h02, 8'h02);
    print_verdict();
  end
endmodule // sspc_ctrl_bench
